// [common/pwrseq_pkg.sv]
// Shared constants and types for the sleep and wake power controller
package pwrseq_pkg;

  localparam int CLK_MHZ = 125;

  // Sleeping and working states, Gray coded along S5-S0-S1-S3-S4
  typedef enum logic [2:0] {
    PS_S5 = 3'h0,
    PS_S0 = 3'h1,
    PS_S1 = 3'h3,
    PS_S3 = 3'h2,
    PS_S4 = 3'h6
  } pstate_t;

  // One bit per wake source; usb is bit 0
  typedef struct packed {
    logic net;
    logic pme;
    logic sw;
    logic ps2;
    logic rtc;
    logic serial;
    logic usb;
  } wake_src_t;

  typedef struct packed {
    logic [1:0] policy;
    logic       sleep_s3;
    logic       dual_led;
    logic       pm_event_wake_enable;
  } ctrl_t;

  typedef struct packed {
    logic [7:0] duty;
    logic [7:0] tach;
  } fan_stat_t;

  // Restore policy after AC loss
  localparam logic [1:0] RESTORE_OFF  = 2'h0;
  localparam logic [1:0] RESTORE_ON   = 2'h1;
  localparam logic [1:0] RESTORE_LAST = 2'h2;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_SLEEP_CMD = 8'h04;
  localparam logic [7:0] REG_STATE     = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h10;
  localparam logic [7:0] REG_FAN_TGT   = 8'h14;
  localparam logic [7:0] REG_FAN_STAT  = 8'h18;

  // Sleep command codes
  localparam logic [2:0] CMD_S1 = 3'h1;
  localparam logic [2:0] CMD_S3 = 3'h3;
  localparam logic [2:0] CMD_S4 = 3'h4;
  localparam logic [2:0] CMD_S5 = 3'h5;

  // Interrupt status bit positions
  localparam int IRQ_WAKE  = 0;
  localparam int IRQ_SHORT = 1;
  localparam int IRQ_LONG  = 2;
  localparam int IRQ_BOOT  = 3;

  localparam ctrl_t      CTRL_RST    = '{policy: RESTORE_LAST, default: 1'b0};
  localparam logic [7:0] FAN_TGT_RST = 8'h3c;

  // Times and their cycle counts
  localparam int LONG_PRESS_MS       = 4000;
  localparam int LONG_PRESS_CYC_DEF  = LONG_PRESS_MS * CLK_MHZ * 1000;
  localparam int PLT_RST_US          = 16;
  localparam int PLT_RST_CYC         = PLT_RST_US * CLK_MHZ;
  localparam int TACH_WIN_MS         = 1000;
  localparam int TACH_WIN_CYC_DEF    = TACH_WIN_MS * CLK_MHZ * 1000;
  localparam int FAN_LOOP_MS         = 100;
  localparam int FAN_LOOP_CYC_DEF    = FAN_LOOP_MS * CLK_MHZ * 1000;
  localparam int PWM_DIV_CYC         = 20;

endpackage

// [dv/sleep_wake_power_control_test.sv]
// Self-checking bench for the sleep and wake power controller
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_power_control_test import pwrseq_pkg::*;;
  logic            mclk, rst_b, wr, rd, irq, rails, last_on, ps_on_b, plt_b, green, amber;
  logic [7:0]      addr;
  logic [31:0]     wdata, rdata, d;
  logic [1:0]      pol, tach, pwm, saved_pol;
  logic            saved_on;
  logic [1:0][7:0] temp;
  wake_src_t       fire, act;
  pstate_t         st;
  int              n_errors = 0, n_tests = 0, s, k, hi, it;
  // Hand-picked corners run first, then random pairs
  int              cs[6] = '{0, 3, 1, 5, 6, 0};
  int              ck[6] = '{1, 2, 0, 2, 3, 2};
  pstate_t         sts[4] = '{PS_S1, PS_S3, PS_S4, PS_S5};
  logic [2:0]      cmds[4] = '{CMD_S1, CMD_S3, CMD_S4, CMD_S5};

  wake_peer i_peer (.mclk_i(mclk), .ps_on_b_i(ps_on_b), .fire_i(fire), .act_o(act),
                    .rails_o(rails), .tach_o(tach));

  sleep_wake_power_control #(.LONG_PRESS_CYC(20), .TACH_WIN_CYC(64), .FAN_LOOP_CYC(16)) i_dut (
    .mclk_i(mclk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq), .usb_act_i(act.usb), .ps2_act_i(act.ps2),
    .serial_act_i(act.serial), .pme_b_i(~act.pme), .net_wake_i(act.net),
    .rtc_alarm_i(act.rtc), .pwr_sw_b_i(~act.sw), .last_on_i(last_on),
    .restore_policy_i(pol), .last_on_o(saved_on), .restore_policy_o(saved_pol),
    .ps_on_b_o(ps_on_b), .plt_rst_b_o(plt_b), .led_green_o(green), .led_amber_o(amber),
    .fan_temp_i(temp),
    .fan_tach_i(tach), .fan_pwm_o(pwm));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Ends just past an edge so outputs have settled
  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic check_state(input pstate_t e);
    rd_reg(REG_STATE);
    check("state", d[2:0], e);
  endtask

  task automatic fire_src(input int i, input int hold);
    @(posedge mclk);
    fire <= wake_src_t'(7'(1 << i));
    cycles(hold);
    fire <= '0;
    cycles(8);
  endtask

  // Bounded wait for the supply request to reach a level
  task automatic wait_ps(input logic v);
    k = 0;
    while (ps_on_b !== v && k < 40) begin
      cycles(1);
      k++;
    end
    if (ps_on_b !== v) begin
      n_errors++;
      finish_test;
    end
  endtask

  // Bit order usb, serial, rtc, ps2, sw, pme, net; wake on event enabled
  function automatic logic allowed(input int i, input pstate_t p);
    if (p == PS_S1 || p == PS_S3) return 1'b1;
    return i == 2 || i == 4 || i == 5 || i == 6;
  endfunction

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    finish_test;
  end

  initial begin
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    fire = '0;
    last_on = 1'b1;
    pol = RESTORE_OFF;
    temp = {2{8'hff}};
    s = $urandom(32'he229);
    cycles(5);
    rst_b <= 1'b1;
    cycles(3);
    check_state(PS_S5);
    fire_src(5, 1);
    check_state(PS_S5);
    wr_reg(REG_CTRL, 32'h13);
    wr_reg(REG_IRQ_MASK, 32'h1);
    fire_src(2, 1);
    check_state(PS_S0);
    wait_ps(1'b0);
    cycles(PLT_RST_CYC);
    rd_reg(REG_IRQ_STAT);
    cycles(2);
    check("irq_clear", irq, 1'b0);
    $display("Boot and restore test done");
    for (it = 0; it < 26; it++) begin
      k = (it < 6) ? ck[it] : $urandom_range(3);
      s = (it < 6) ? cs[it] : $urandom_range(6);
      st = sts[k];
      wr_reg(REG_SLEEP_CMD, 32'(cmds[k]));
      cycles(4);
      check_state(st);
      if (st == PS_S3) begin
        check("amber", {amber, green, ps_on_b}, 3'b101);
        check("fan_off", pwm, 2'b00);
      end
      if (st == PS_S5) check("rails", rails, 1'b0);
      fire_src(s, (s == 4) ? 3 : 1);
      check_state(allowed(s, st) ? PS_S0 : st);
      if (it == 0) check("irq_wake", irq, 1'b1);
      if (st == PS_S3) check("warm_wake", plt_b, 1'b1);
      if (!allowed(s, st)) fire_src(4, 3);
      wait_ps(1'b0);
      if (st inside {PS_S4, PS_S5}) cycles(PLT_RST_CYC + 4);
    end
    $display("Wake source test done");
    fire_src(4, 3);
    check_state(PS_S1);
    fire_src(4, 25);
    check_state(PS_S5);
    rd_reg(8'hfc);
    check("unmapped", d, 32'h0);
    check("saved_on", saved_on, 1'b0);
    $display("Power switch test done");
    rst_b <= 1'b0;
    cycles(5);
    pol <= RESTORE_LAST;
    rst_b <= 1'b1;
    cycles(3);
    check_state(PS_S0);
    check("saved", {saved_on, saved_pol}, {1'b1, RESTORE_LAST});
    hi = 0;
    repeat (5200) begin
      cycles(1);
      hi += int'(pwm == 2'b11);
    end
    check("fan_on", hi != 0, 1'b1);
    // Peer tach periods of 4 and 16 cycles over a 64-cycle window
    rd_reg(REG_FAN_STAT);
    check("tach", {d[23:16], d[7:0]}, 16'h0410);
    check("duty", {d[31:24], d[15:8]}, 16'hffff);
    rst_b <= 1'b0;
    last_on <= 1'b0;
    pol <= RESTORE_ON;
    cycles(5);
    rst_b <= 1'b1;
    cycles(3);
    check_state(PS_S0);
    check("saved_pol", saved_pol, RESTORE_ON);
    wr_reg(REG_CTRL, 32'h4);
    fire_src(4, 3);
    check_state(PS_S3);
    check("led_single", {amber, green, ps_on_b}, 3'b001);
    $display("Restore and fan test done");
    finish_test;
  end
endmodule
`default_nettype wire

// [dv/wake_peer.sv]
// Model of the wake peripherals, the supply rails and the two fan tachometers
`timescale 1ns/1ps
`default_nettype none
module wake_peer import pwrseq_pkg::*; (
  // Clock and supply request
  input  wire logic      mclk_i,
  input  wire logic      ps_on_b_i,
  // Wake requests from the bench
  input  wire wake_src_t fire_i,
  // Pins toward the controller, and the rail level for the bench
  output var wake_src_t  act_o,
  output var logic       rails_o,
  output var logic [1:0] tach_o
);
  logic [3:0] div;

  initial begin
    act_o = '0;
    rails_o = 1'b0;
    tach_o = 2'b00;
    div = 4'h0;
  end

  always @(posedge mclk_i) begin
    // Frame match reduced to a wake pulse; the bench picks the moment
    act_o   <= fire_i;
    // Everything but standby drops while supply-on is released
    rails_o <= !ps_on_b_i;
    div     <= div + 4'h1;
    // Two fans at distinct speeds so a swapped tach shows
    tach_o  <= {div[3], div[1]};
  end
endmodule
`default_nettype wire

// [rtl/fan_ctrl.sv]
// One fan channel: tach counting, closed-loop duty and PWM drive
`timescale 1ns/1ps
`default_nettype none
module fan_ctrl import pwrseq_pkg::*; #(
  parameter int WIN_CYC  = TACH_WIN_CYC_DEF,
  parameter int LOOP_CYC = FAN_LOOP_CYC_DEF
) (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // Control
  input  wire logic       en_i,
  input  wire logic [7:0] temp_i,
  input  wire logic [7:0] target_i,
  input  wire logic       tach_i,
  // Drive and status
  output logic            pwm_o,
  output fan_stat_t       stat_o
);

  logic [31:0] win_ff, nxt_win;
  logic [31:0] loop_ff, nxt_loop;
  logic [7:0]  div_ff, nxt_div;
  logic [7:0]  ramp_ff, nxt_ramp;
  logic [7:0]  edges_ff, nxt_edges;
  logic        tach_d_ff, nxt_tach_d;
  logic        pwm_ff, nxt_pwm;
  fan_stat_t   stat_ff, nxt_stat;
  logic        tick;

  assign tick = (loop_ff == 32'(LOOP_CYC - 1));

  always_comb begin
    nxt_tach_d = tach_i;
    nxt_win    = (win_ff == 32'(WIN_CYC - 1)) ? 32'h0 : win_ff + 32'h1;
    nxt_loop   = tick ? 32'h0 : loop_ff + 32'h1;
    nxt_div    = (div_ff == 8'(PWM_DIV_CYC - 1)) ? 8'h0 : div_ff + 8'h1;
    nxt_ramp   = (div_ff == 8'(PWM_DIV_CYC - 1)) ? ramp_ff + 8'h1 : ramp_ff;
    nxt_edges  = edges_ff;
    nxt_stat   = stat_ff;
    // Each fan counts its own tach edges per window
    if (tach_i && !tach_d_ff && edges_ff != 8'hff) begin
      nxt_edges = edges_ff + 8'h1;
    end
    if (win_ff == 32'(WIN_CYC - 1)) begin
      nxt_stat.tach = nxt_edges;
      nxt_edges     = 8'h0;
    end
    if (!en_i) begin
      nxt_stat.duty = 8'h0;
    end else if (tick) begin
      if (temp_i > target_i && stat_ff.duty != 8'hff) begin
        nxt_stat.duty = stat_ff.duty + 8'h1;
      end else if (temp_i < target_i && stat_ff.duty != 8'h0) begin
        nxt_stat.duty = stat_ff.duty - 8'h1;
      end
    end
    nxt_pwm = en_i && (ramp_ff < stat_ff.duty);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      win_ff    <= 32'h0;
      loop_ff   <= 32'h0;
      div_ff    <= 8'h0;
      ramp_ff   <= 8'h0;
      edges_ff  <= 8'h0;
      tach_d_ff <= 1'b0;
      pwm_ff    <= 1'b0;
      stat_ff   <= '0;
    end else begin
      win_ff    <= nxt_win;
      loop_ff   <= nxt_loop;
      div_ff    <= nxt_div;
      ramp_ff   <= nxt_ramp;
      edges_ff  <= nxt_edges;
      tach_d_ff <= nxt_tach_d;
      pwm_ff    <= nxt_pwm;
      stat_ff   <= nxt_stat;
    end
  end

  assign pwm_o  = pwm_ff;
  assign stat_o = stat_ff;

  chk_loop_raise: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (en_i && tick && temp_i > target_i && stat_ff.duty != 8'hff)
      |=> stat_ff.duty == $past(stat_ff.duty) + 8'h1)
    else $error("duty not raised on hot reading");
  chk_pwm_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !en_i |=> !pwm_o ##1 (!pwm_o || en_i))
    else $error("fan driven while disabled");

endmodule
`default_nettype wire

// [rtl/press_timer.sv]
// Power switch press length classifier: short press on release, long press while held
`timescale 1ns/1ps
`default_nettype none
module press_timer import pwrseq_pkg::*; #(
  parameter int LONG_CYC = LONG_PRESS_CYC_DEF
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  // Switch level and events
  input  wire logic pressed_i,
  output logic      short_o,
  output logic      long_o
);

  logic [31:0] cnt_ff, nxt_cnt;
  logic        held_ff, nxt_held;
  logic        done_ff, nxt_done;
  logic        short_ff, nxt_short;
  logic        long_ff, nxt_long;

  always_comb begin
    nxt_held  = pressed_i;
    nxt_cnt   = pressed_i ? cnt_ff : 32'h0;
    nxt_done  = pressed_i & done_ff;
    nxt_short = 1'b0;
    nxt_long  = 1'b0;
    if (pressed_i && !done_ff) begin
      if (cnt_ff == 32'(LONG_CYC - 1)) begin
        nxt_long = 1'b1;
        nxt_done = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 32'h1;
      end
    end
    // A press that already counted as long gives no short event on release
    if (!pressed_i && held_ff && !done_ff) begin
      nxt_short = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cnt_ff   <= 32'h0;
      held_ff  <= 1'b0;
      done_ff  <= 1'b0;
      short_ff <= 1'b0;
      long_ff  <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      held_ff  <= nxt_held;
      done_ff  <= nxt_done;
      short_ff <= nxt_short;
      long_ff  <= nxt_long;
    end
  end

  assign short_o = short_ff;
  assign long_o  = long_ff;

  chk_long_after_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    long_o |-> $past(cnt_ff) == 32'(LONG_CYC - 1) && $past(pressed_i))
    else $error("long press not after full hold");
  chk_short_on_release: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    short_o |-> !$past(pressed_i) && $past(pressed_i, 2) && !long_o)
    else $error("short press not at release");

endmodule
`default_nettype wire

// [rtl/sleep_wake_power_control.sv]
// Sleep state, wake source, fan, panel LED and AC restore controller
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_power_control import pwrseq_pkg::*; #(
  parameter int LONG_PRESS_CYC = LONG_PRESS_CYC_DEF,
  parameter int TACH_WIN_CYC   = TACH_WIN_CYC_DEF,
  parameter int FAN_LOOP_CYC   = FAN_LOOP_CYC_DEF
) (
  // Clock and reset
  input  wire logic            mclk_i,
  input  wire logic            rst_b_i,
  // Register port
  input  wire logic [7:0]      reg_addr_i,
  input  wire logic [31:0]     reg_wdata_i,
  input  wire logic            reg_wr_i,
  input  wire logic            reg_rd_i,
  output logic      [31:0]     reg_rdata_o,
  output logic                 irq_o,
  // Wake sources
  input  wire logic            usb_act_i,
  input  wire logic            ps2_act_i,
  input  wire logic            serial_act_i,
  input  wire logic            pme_b_i,
  input  wire logic            net_wake_i,
  input  wire logic            rtc_alarm_i,
  input  wire logic            pwr_sw_b_i,
  // Battery-held settings
  input  wire logic            last_on_i,
  input  wire logic [1:0]      restore_policy_i,
  output logic                 last_on_o,
  output logic      [1:0]      restore_policy_o,
  // Supply and panel
  output logic                 ps_on_b_o,
  output logic                 plt_rst_b_o,
  output logic                 led_green_o,
  output logic                 led_amber_o,
  // Fans: index 0 processor, index 1 front
  input  wire logic [1:0][7:0] fan_temp_i,
  input  wire logic [1:0]      fan_tach_i,
  output logic      [1:0]      fan_pwm_o
);

  function automatic wake_src_t allowed_src(pstate_t s, logic pme_en);
    wake_src_t a;
    a = '0;
    if (s == PS_S1 || s == PS_S3) begin
      a = '1;
      a.pme = pme_en;
    end else if (s == PS_S4 || s == PS_S5) begin
      a.net = 1'b1;
      a.pme = pme_en;
      a.sw  = 1'b1;
      a.rtc = 1'b1;
    end
    return a;
  endfunction

  pstate_t          state_ff, nxt_state;
  ctrl_t            ctrl_ff, nxt_ctrl;
  logic             boot_ff, nxt_boot;
  logic [15:0]      prst_ff, nxt_prst;
  logic [3:0]       stat_ff, nxt_stat;
  logic [3:0]       mask_ff, nxt_mask;
  logic [1:0][7:0]  tgt_ff, nxt_tgt;
  wake_src_t        last_src_ff, nxt_last_src;
  logic [31:0]      rdata_ff, nxt_rdata;
  logic             irq_ff, nxt_irq;
  logic             ps_on_b_ff, nxt_ps_on_b;
  logic             green_ff, nxt_green;
  logic             amber_ff, nxt_amber;
  logic             last_on_ff, nxt_last_on;
  logic             plt_b_ff, nxt_plt_b;
  logic             short_pr;
  logic             long_pr;
  logic             fan_en;
  wake_src_t        src;
  wake_src_t        hit;
  fan_stat_t [1:0]  fan_stat;
  logic [3:0]       events;
  logic             sleeping;
  logic             wr_cmd;

  press_timer #(
    .LONG_CYC (LONG_PRESS_CYC)
  ) u_press (
    .mclk_i    (mclk_i),
    .rst_b_i   (rst_b_i),
    .pressed_i (!pwr_sw_b_i),
    .short_o   (short_pr),
    .long_o    (long_pr)
  );

  // Fans run in S0 and in S1, where the processor keeps its power
  assign fan_en = (state_ff == PS_S0) || (state_ff == PS_S1);

  for (genvar f = 0; f < 2; f++) begin : g_fan
    fan_ctrl #(
      .WIN_CYC  (TACH_WIN_CYC),
      .LOOP_CYC (FAN_LOOP_CYC)
    ) u_fan (
      .mclk_i   (mclk_i),
      .rst_b_i  (rst_b_i),
      .en_i     (fan_en),
      .temp_i   (fan_temp_i[f]),
      .target_i (tgt_ff[f]),
      .tach_i   (fan_tach_i[f]),
      .pwm_o    (fan_pwm_o[f]),
      .stat_o   (fan_stat[f])
    );
  end

  always_comb begin
    src        = '0;
    src.net    = net_wake_i;
    src.pme    = !pme_b_i;
    src.sw     = short_pr;
    src.ps2    = ps2_act_i;
    src.rtc    = rtc_alarm_i;
    src.serial = serial_act_i;
    src.usb    = usb_act_i;
  end

  // Disallowed sources are masked here and never stored
  assign hit      = src & allowed_src(state_ff, ctrl_ff.pm_event_wake_enable);
  assign sleeping = (state_ff != PS_S0);
  assign wr_cmd   = reg_wr_i && (reg_addr_i == REG_SLEEP_CMD);

  // Power state sequencing
  always_comb begin
    nxt_state    = state_ff;
    nxt_boot     = 1'b0;
    nxt_prst     = (prst_ff != 16'h0) ? prst_ff - 16'h1 : 16'h0;
    nxt_last_src = last_src_ff;
    if (boot_ff) begin
      if (restore_policy_i == RESTORE_ON ||
          (restore_policy_i == RESTORE_LAST && last_on_i)) begin
        nxt_state = PS_S0;
        nxt_prst  = 16'(PLT_RST_CYC);
      end else begin
        nxt_state = PS_S5;
      end
    end else if (long_pr) begin
      nxt_state = PS_S5;
    end else if (!sleeping) begin
      if (wr_cmd) begin
        unique case (reg_wdata_i[2:0])
          CMD_S1:  nxt_state = PS_S1;
          CMD_S3:  nxt_state = PS_S3;
          CMD_S4:  nxt_state = PS_S4;
          CMD_S5:  nxt_state = PS_S5;
          default: nxt_state = state_ff;
        endcase
      end else if (short_pr) begin
        nxt_state = ctrl_ff.sleep_s3 ? PS_S3 : PS_S1;
      end
    end else if (hit != '0) begin
      nxt_state    = PS_S0;
      nxt_last_src = hit;
      // Only a resume from disk or soft-off needs a platform reset
      if (state_ff == PS_S4 || state_ff == PS_S5) begin
        nxt_prst = 16'(PLT_RST_CYC);
      end
    end
    nxt_plt_b    = (nxt_prst == 16'h0) && nxt_state != PS_S5 && nxt_state != PS_S4;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      state_ff    <= PS_S5;
      boot_ff     <= 1'b1;
      prst_ff     <= 16'h0;
      last_src_ff <= '0;
      plt_b_ff    <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      boot_ff     <= nxt_boot;
      prst_ff     <= nxt_prst;
      last_src_ff <= nxt_last_src;
      plt_b_ff    <= nxt_plt_b;
    end
  end

  // Supply, LED and saved-state outputs
  always_comb begin
    nxt_ps_on_b = !(state_ff == PS_S0 || state_ff == PS_S1);
    nxt_green   = (state_ff == PS_S0 || state_ff == PS_S1);
    nxt_amber   = (state_ff == PS_S3) && ctrl_ff.dual_led;
    nxt_last_on = boot_ff ? last_on_ff : (state_ff != PS_S5 && state_ff != PS_S4);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ps_on_b_ff <= 1'b1;
      green_ff   <= 1'b0;
      amber_ff   <= 1'b0;
      last_on_ff <= 1'b0;
    end else begin
      ps_on_b_ff <= nxt_ps_on_b;
      green_ff   <= nxt_green;
      amber_ff   <= nxt_amber;
      last_on_ff <= nxt_last_on;
    end
  end

  // Register file and interrupt
  assign events = {boot_ff, long_pr, short_pr, sleeping && (hit != '0)};

  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_mask  = mask_ff;
    nxt_tgt   = tgt_ff;
    nxt_rdata = 32'h0;
    nxt_stat  = stat_ff | events;
    if (boot_ff) begin
      nxt_ctrl.policy = restore_policy_i;
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        REG_CTRL:     nxt_ctrl = reg_wdata_i[4:0];
        REG_IRQ_MASK: nxt_mask = reg_wdata_i[3:0];
        REG_FAN_TGT:  nxt_tgt  = reg_wdata_i[15:0];
        default:      nxt_ctrl = nxt_ctrl;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_CTRL:     nxt_rdata = {27'h0, ctrl_ff};
        REG_STATE:    nxt_rdata = {19'h0, last_on_ff, last_src_ff, 2'h0, state_ff};
        REG_IRQ_STAT: nxt_rdata = {28'h0, stat_ff};
        REG_IRQ_MASK: nxt_rdata = {28'h0, mask_ff};
        REG_FAN_TGT:  nxt_rdata = {16'h0, tgt_ff};
        REG_FAN_STAT: nxt_rdata = fan_stat;
        default:      nxt_rdata = 32'h0;
      endcase
      // New events in the reading cycle survive the clear
      if (reg_addr_i == REG_IRQ_STAT) begin
        nxt_stat = events;
      end
    end
    nxt_irq = |(nxt_stat & nxt_mask);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ctrl_ff  <= CTRL_RST;
      mask_ff  <= 4'h0;
      tgt_ff   <= {FAN_TGT_RST, FAN_TGT_RST};
      rdata_ff <= 32'h0;
      stat_ff  <= 4'h0;
      irq_ff   <= 1'b0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      mask_ff  <= nxt_mask;
      tgt_ff   <= nxt_tgt;
      rdata_ff <= nxt_rdata;
      stat_ff  <= nxt_stat;
      irq_ff   <= nxt_irq;
    end
  end

  assign reg_rdata_o      = rdata_ff;
  assign irq_o            = irq_ff;
  assign ps_on_b_o        = ps_on_b_ff;
  assign plt_rst_b_o      = plt_b_ff;
  assign led_green_o      = green_ff;
  assign led_amber_o      = amber_ff;
  assign last_on_o        = last_on_ff;
  assign restore_policy_o = ctrl_ff.policy;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  logic light;
  logic deep;
  logic calm;
  assign light = (state_ff == PS_S1) || (state_ff == PS_S3);
  assign deep  = (state_ff == PS_S4) || (state_ff == PS_S5);
  assign calm  = !boot_ff && !long_pr;

  sequence s3_resume;
    state_ff == PS_S3 ##1 state_ff == PS_S0;
  endsequence

  chk_usb_wake: assert property (light && calm && usb_act_i |=> state_ff == PS_S0)
    else $error("usb activity did not wake from light sleep");
  chk_usb_deep: assert property (deep && calm && src == 7'h01 |=> $stable(state_ff))
    else $error("usb activity acted in deep sleep");
  chk_ps2_wake: assert property (light && calm && ps2_act_i |=> state_ff == PS_S0)
    else $error("ps2 activity did not wake");
  chk_serial_deep: assert property (deep && calm && src == 7'h02 |=> $stable(state_ff))
    else $error("serial activity acted in deep sleep");
  chk_pme_gate: assert property (sleeping && calm && src == 7'h20
    |=> (state_ff == PS_S0) == $past(ctrl_ff.pm_event_wake_enable))
    else $error("pme wake not gated by its enable");
  chk_net_wake: assert property (sleeping && calm && net_wake_i |=> state_ff == PS_S0)
    else $error("network wake ignored");
  chk_s3_outputs: assert property ((state_ff == PS_S3) [*2]
    |-> ps_on_b_o && !led_green_o && led_amber_o == $past(ctrl_ff.dual_led))
    else $error("supply or led wrong in s3");
  chk_s3_warm: assert property (s3_resume |-> plt_rst_b_o ##1 plt_rst_b_o)
    else $error("resume from s3 took a platform reset");
  chk_fan_state: assert property ((deep || state_ff == PS_S3) [*2]
    |-> fan_pwm_o == 2'b00)
    else $error("fans driven while off or suspended");
  chk_off_cmd: assert property (!sleeping && calm && wr_cmd && reg_wdata_i[2:0] == CMD_S5
    |=> state_ff == PS_S5 ##1 ps_on_b_o)
    else $error("power-off command did not drop supply");
  chk_restore: assert property (boot_ff && restore_policy_i == RESTORE_LAST
    |=> (state_ff == PS_S0) == $past(last_on_i) ##1 ps_on_b_o == !$past(last_on_i, 2))
    else $error("ac restore ignored saved state");
  chk_sw_wake: assert property (sleeping && calm && short_pr |=> state_ff == PS_S0)
    else $error("power switch did not wake");
  chk_long_off: assert property (!boot_ff && long_pr |=> state_ff == PS_S5)
    else $error("long press did not force soft-off");

endmodule
`default_nettype wire
